/* rtl/cscx_pkg.sv */
// Package with opcode patterns, phase codes and bank constants for the compare/complement executor
package cscx_pkg;
	localparam logic [6:0] CSCX_OP_CPSEQ = 7'h31;
	localparam logic [6:0] CSCX_OP_CPSGT = 7'h32;
	localparam logic [5:0] CSCX_OP_COMPLEMENT_FILE_OP = 6'h07;
	localparam int CSCX_POS_BANKBIT = 8;
	localparam int CSCX_POS_DESTBIT = 9;
	localparam logic [7:0] CSCX_ACCESS_SPLIT = 8'h80;
	localparam logic [3:0] CSCX_ACCESS_HIGH_BANK = 4'hf;
	localparam logic [3:0] CSCX_ACCESS_LOW_BANK = 4'h0;
	localparam logic [7:0] CSCX_ACC_RESET = 8'h00;
	localparam logic [3:0] CSCX_BSR_RESET = 4'h0;
	typedef enum logic [3:0] {
		CSCX_Q1 = 4'b0001,
		CSCX_Q2 = 4'b0010,
		CSCX_Q3 = 4'b0100,
		CSCX_Q4 = 4'b1000
	} cscx_phase_t;
endpackage

/* rtl/cscx_skip_counter.sv */
// Skip tracker that turns discarded instruction words into no-operation cycles
`timescale 1ns/100ps
module cscx_skip_counter (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_cycle_end,
	input wire logic i_skip_set,
	input wire logic i_next_two_word,
	output logic o_flush
);
	logic [1:0] skip_left_reg;
	logic [1:0] skip_left_next;

	always_comb begin
		skip_left_next = skip_left_reg;
		if (i_cycle_end) begin
			if (i_skip_set) begin
				skip_left_next = i_next_two_word ? 2'h2 : 2'h1;
			end else if (skip_left_reg != 2'h0) begin
				skip_left_next = skip_left_reg - 2'h1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			skip_left_reg <= 2'h0;
		end else begin
			skip_left_reg <= skip_left_next;
		end
	end

	assign o_flush = (skip_left_reg != 2'h0);
endmodule

/* rtl/cscx_exec.sv */
// Execution unit for complement and compare-skip instructions
`timescale 1ns/100ps
module cscx_exec (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [15:0] i_instr,
	input wire logic i_next_two_word,
	input wire logic [3:0] i_bank_select_register,
	input wire logic [7:0] i_mem_rdata,
	input wire logic i_acc_we,
	input wire logic [7:0] i_acc_wdata,
	output logic [11:0] o_mem_addr,
	output logic o_mem_re,
	output logic o_mem_we,
	output logic [7:0] o_mem_wdata,
	output logic [7:0] o_accumulator_register,
	output logic o_flag_n,
	output logic o_flag_z,
	output logic [3:0] o_phase,
	output logic o_flush,
	output logic o_busy_nop
);
	cscx_pkg::cscx_phase_t phase_reg;
	logic [15:0] instr_reg;
	logic [7:0] operand_reg;
	logic [7:0] result_reg;
	logic skip_reg;
	logic [7:0] acc_reg;
	logic flag_n_reg;
	logic flag_z_reg;
	logic [11:0] addr_reg;
	logic we_reg;
	logic is_cpseq;
	logic is_cpsgt;
	logic is_complement_file_op;
	logic flush;
	logic [11:0] eff_addr;
	logic [8:0] diff;
	logic [7:0] inv_bits;
	logic cmp_equal;
	logic cmp_greater;
	logic in_q1;
	logic in_q2;
	logic in_q3;
	logic in_q4;
	logic op_live;
	logic dest_is_file;
	logic bank_override;
	logic addr_in_high_half;

	// Phase strobes
	assign in_q1 = (phase_reg == cscx_pkg::CSCX_Q1);
	assign in_q2 = (phase_reg == cscx_pkg::CSCX_Q2);
	assign in_q3 = (phase_reg == cscx_pkg::CSCX_Q3);
	assign in_q4 = (phase_reg == cscx_pkg::CSCX_Q4);

	// Words fetched during a forced no-operation are ignored
	assign op_live = !flush;
	assign is_cpsgt = (instr_reg[15:9] == cscx_pkg::CSCX_OP_CPSGT) && op_live;
	assign is_cpseq = (instr_reg[15:9] == cscx_pkg::CSCX_OP_CPSEQ) && op_live;
	assign is_complement_file_op = (instr_reg[15:10] == cscx_pkg::CSCX_OP_COMPLEMENT_FILE_OP) && op_live;
	assign dest_is_file = instr_reg[cscx_pkg::CSCX_POS_DESTBIT];

	// Unsigned compare from a nine-bit difference
	assign diff = {1'b0, operand_reg} - {1'b0, acc_reg};
	assign cmp_equal = (diff[7:0] == 8'h00);
	assign cmp_greater = !diff[8] && !cmp_equal;

	// Bitwise inverse of the source register
	for (genvar bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_invert
		assign inv_bits[bit_idx] = ~operand_reg[bit_idx];
	end

	// Effective data address
	assign bank_override = i_instr[cscx_pkg::CSCX_POS_BANKBIT];
	assign addr_in_high_half = (i_instr[7:0] >= cscx_pkg::CSCX_ACCESS_SPLIT);
	always_comb begin
		if (bank_override) begin
			eff_addr = {i_bank_select_register, i_instr[7:0]};
		end else if (addr_in_high_half) begin
			eff_addr = {cscx_pkg::CSCX_ACCESS_HIGH_BANK, i_instr[7:0]};
		end else begin
			eff_addr = {cscx_pkg::CSCX_ACCESS_LOW_BANK, i_instr[7:0]};
		end
	end

	// Four phases per instruction cycle
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			phase_reg <= cscx_pkg::CSCX_Q1;
		end else begin
			case (phase_reg)
				cscx_pkg::CSCX_Q1: phase_reg <= cscx_pkg::CSCX_Q2;
				cscx_pkg::CSCX_Q2: phase_reg <= cscx_pkg::CSCX_Q3;
				cscx_pkg::CSCX_Q3: phase_reg <= cscx_pkg::CSCX_Q4;
				cscx_pkg::CSCX_Q4: phase_reg <= cscx_pkg::CSCX_Q1;
				default: phase_reg <= cscx_pkg::CSCX_Q1;
			endcase
		end
	end

	// Decode latches the word
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			instr_reg <= 16'h0000;
		end else if (in_q1) begin
			instr_reg <= i_instr;
		end
	end

	// Data address held from Q2 on
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			addr_reg <= 12'h000;
		end else if (in_q1) begin
			addr_reg <= eff_addr;
		end
	end

	// Source register read
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			operand_reg <= 8'h00;
		end else if (in_q2) begin
			operand_reg <= i_mem_rdata;
		end
	end

	// Complement result
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			result_reg <= 8'h00;
		end else if (in_q3) begin
			result_reg <= inv_bits;
		end
	end

	// Skip decision, shown during Q4 only
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			skip_reg <= 1'b0;
		end else if (in_q3) begin
			skip_reg <= (is_cpseq && cmp_equal) || (is_cpsgt && cmp_greater);
		end else if (in_q4) begin
			skip_reg <= 1'b0;
		end
	end

	// Write destination; compares write nothing
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			acc_reg <= cscx_pkg::CSCX_ACC_RESET;
		end else if (in_q4 && is_complement_file_op && !dest_is_file) begin
			acc_reg <= result_reg;
		end else if (i_acc_we) begin
			acc_reg <= i_acc_wdata;
		end
	end

	// Negative flag, complement only
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			flag_n_reg <= 1'b0;
		end else if (in_q4 && is_complement_file_op) begin
			flag_n_reg <= result_reg[7];
		end
	end

	// Zero flag, complement only
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			flag_z_reg <= 1'b0;
		end else if (in_q4 && is_complement_file_op) begin
			flag_z_reg <= (result_reg == 8'h00);
		end
	end

	// File write strobe during Q4
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			we_reg <= 1'b0;
		end else begin
			we_reg <= in_q3 && is_complement_file_op && dest_is_file;
		end
	end

	// Inverted data for the file write
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			o_mem_wdata <= 8'h00;
		end else begin
			o_mem_wdata <= inv_bits;
		end
	end

	// Counts the no-operation cycles after a skip
	cscx_skip_counter u_skip (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_cycle_end(in_q4),
		.i_skip_set(skip_reg),
		.i_next_two_word(i_next_two_word),
		.o_flush(flush)
	);

	assign o_mem_addr = addr_reg;
	assign o_mem_re = (phase_reg == cscx_pkg::CSCX_Q2) && !flush;
	assign o_mem_we = we_reg;
	assign o_accumulator_register = acc_reg;
	assign o_flag_n = flag_n_reg;
	assign o_flag_z = flag_z_reg;
	assign o_phase = phase_reg;
	assign o_flush = skip_reg;
	assign o_busy_nop = flush;
endmodule

/* test/cscx_properties.sv */
// Checker of phase, skip and complement timing
`timescale 1ns/100ps
module cscx_properties (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_next_two_word,
	input wire logic o_mem_re,
	input wire logic o_mem_we,
	input wire logic o_flag_n,
	input wire logic o_flag_z,
	input wire logic o_flush,
	input wire logic o_busy_nop,
	input wire logic [7:0] i_mem_rdata,
	input wire logic [7:0] o_mem_wdata,
	input wire logic [3:0] o_phase
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_phase_wrap: assert property (o_phase == 4'h8 |=> o_phase == 4'h1) else $error("phase");
	a_read_q2: assert property (o_mem_re |-> o_phase == 4'h2 && !o_busy_nop) else $error("read");
	a_flush_q4: assert property (o_flush |-> o_phase == 4'h8) else $error("flush");
	a_skip_nops: assert property (o_flush |=> o_busy_nop [*4]) else $error("nop");
	a_one_nop: assert property ($rose(o_busy_nop) && !$past(i_next_two_word) |-> o_busy_nop [*4] ##1 !o_busy_nop)
		else $error("nop1");
	a_two_nops: assert property ($rose(o_busy_nop) && $past(i_next_two_word) |-> o_busy_nop [*8] ##1 !o_busy_nop)
		else $error("nop2");
	a_write_inv: assert property (o_mem_we |-> o_phase == 4'h8 && o_mem_wdata == ~$past(i_mem_rdata, 2))
		else $error("wdata");
	a_flags_hold: assert property (o_phase != 4'h1 |-> $stable({o_flag_n, o_flag_z})) else $error("flags");
	cover property (o_flush);
	cover property (o_mem_we);
	cover property ($rose(o_busy_nop) && $past(i_next_two_word));
endmodule
bind cscx_exec cscx_properties cscx_properties_inst (.i_clock, .i_rst_n, .i_next_two_word, .o_mem_re, .o_mem_we,
	.o_flag_n, .o_flag_z, .o_flush, .o_busy_nop, .i_mem_rdata, .o_mem_wdata, .o_phase);

/* test/cscx_exec_tb.sv */
// Testbench for the compare and complement executor
`timescale 1ns/100ps
module cscx_exec_tb;
	logic i_clock = 1'b0, i_rst_n = 1'b0, i_next_two_word = 1'b0, i_acc_we = 1'b0;
	logic [15:0] i_instr = 16'h0000;
	logic [3:0] i_bank_select_register = 4'h0, o_phase;
	logic [7:0] i_mem_rdata = 8'h00, i_acc_wdata = 8'h00, o_mem_wdata, o_accumulator_register, n, wd;
	logic [11:0] o_mem_addr, a;
	logic o_mem_re, o_mem_we, o_flag_n, o_flag_z, o_flush, o_busy_nop, f, w, r;
	int num_errors = 0, samples_checked = 0;
	always #4 i_clock = ~i_clock;
	cscx_exec cscx_exec_inst (.i_clock, .i_rst_n, .i_instr, .i_next_two_word, .i_bank_select_register, .i_mem_rdata,
		.i_acc_we, .i_acc_wdata, .o_mem_addr, .o_mem_re, .o_mem_we, .o_mem_wdata, .o_accumulator_register,
		.o_flag_n, .o_flag_z, .o_phase, .o_flush, .o_busy_nop);
	task conclude;
		$display("%0d errors in %0d checks", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask
	// Loads the accumulator, issues one word at a cycle start, samples address, Q4 outputs, nop phases
	task op(input logic [15:0] ins, input logic [7:0] rd, acc, input logic tw);
		int k;
		k = 0;
		@(posedge i_clock);
		i_acc_we <= 1'b1;
		i_acc_wdata <= acc;
		do begin
			@(posedge i_clock);
			#1 k++;
		end while (o_phase !== 4'h8 && k < 9);
		if (o_phase !== 4'h8) begin
			num_errors++;
			conclude;
		end
		@(posedge i_clock);
		i_acc_we <= 1'b0;
		i_instr <= ins;
		i_mem_rdata <= rd;
		i_next_two_word <= tw;
		@(posedge i_clock);
		i_instr <= 16'h0000;
		#1 a = o_mem_addr;
		r = o_mem_re;
		repeat (2) @(posedge i_clock);
		#1 f = o_flush;
		w = o_mem_we;
		wd = o_mem_wdata;
		n = 8'h00;
		repeat (12) begin
			@(posedge i_clock);
			#1 n += 8'(o_busy_nop);
		end
	endtask
	task t_comp;
		op(16'h1e13, 8'h13, 8'h55, 1'b0);
		chk({w, o_flag_n, o_flag_z, o_accumulator_register}, 16'h0655);
		chk(wd, 16'h00ec);
		op(16'h1d13, 8'hff, 8'h55, 1'b0);
		chk({w, o_flag_n, o_flag_z, o_accumulator_register}, 16'h0100);
	endtask
	task t_skip;
		op(16'h6310, 8'h5a, 8'h5a, 1'b0);
		chk({f, n}, 16'h0104);
		op(16'h6310, 8'h5b, 8'h5a, 1'b0);
		chk({f, n}, 16'h0000);
		op(16'h6410, 8'h80, 8'h80, 1'b0);
		chk({f, n}, 16'h0000);
		op(16'h6510, 8'h10, 8'h20, 1'b0);
		chk({f, n}, 16'h0000);
		op(16'h6510, 8'hff, 8'h00, 1'b1);
		chk({f, n}, 16'h0108);
		chk({o_flag_n, o_flag_z}, 16'h0001);
	endtask
	task t_bank;
		@(posedge i_clock);
		i_bank_select_register <= 4'h5;
		op(16'h6280, 8'h00, 8'h01, 1'b0);
		chk(a, 16'h0f80);
		op(16'h6210, 8'h00, 8'h01, 1'b0);
		chk(a, 16'h0010);
		op(16'h6380, 8'h00, 8'h01, 1'b0);
		chk(a, 16'h0580);
		chk(r, 16'h0001);
	endtask
	initial begin
		repeat (8) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_comp;
		t_skip;
		t_bank;
		conclude;
	end
endmodule
